// >>> seq_pkg.sv
// constants, commands and carriers of the program sequencer
package seq_pkg;

  // instruction cycle phases
  localparam int PHASE_COUNT = 4;
  localparam logic [1:0] PHASE_LAST = 2'h3;
  localparam logic [3:0] PHASE_OH_RESET = 4'h1;

  // fixed program addresses
  localparam logic [15:0] VEC_RESET = 16'h0000;
  localparam logic [15:0] VEC_EXT = 16'h0004;
  localparam logic [15:0] VEC_T0 = 16'h0008;
  localparam logic [15:0] VEC_T1 = 16'h000c;

  // register offsets in the data map, and the value read at unmapped offsets
  localparam logic [7:0] OFF_PTR_LOW = 8'h06;
  localparam logic [7:0] OFF_LOOKUP_INDEX = 8'h07;
  localparam logic [7:0] OFF_LOOKUP_HIGH = 8'h08;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // reset values
  localparam logic [7:0] LOOKUP_INDEX_RESET = 8'h00;
  localparam logic [7:0] LOOKUP_HIGH_RESET = 8'h00;

  // index of each source in the acknowledge vector
  localparam int ACK_EXT = 0;
  localparam int ACK_T0 = 1;
  localparam int ACK_T1 = 2;

  // sequencing request of the executing instruction
  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_JUMP = 3'b001,
    OP_CALL = 3'b010,
    OP_RET = 3'b011,
    OP_ISR_RETURN_OP = 3'b100,
    OP_SKIP = 3'b101,
    OP_TAB_CUR = 3'b110,
    OP_TAB_LAST = 3'b111
  } seq_op_e;

  // sequencer state
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_FLUSH = 2'b01,
    ST_TABLE = 2'b10
  } seq_state_e;

  typedef struct packed {
    seq_op_e op;
    logic [15:0] target;
  } seq_cmd_s;

  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_wr_s;

endpackage : seq_pkg

// >>> program_sequencer_with_stack.sv
// program sequencer: phases, pipeline, pointer, return stack, lookup reads
// How it works
// - four phases make one instruction cycle
// - fetch next word while current one executes
// - pointer changes add one dummy cycle
// - pointer width is a parameter, 10 to 13
// - pointer steps by one after each fetch
// - reset starts execution at word zero
// - enabled external request branches to 004h
// - enabled timer 0 overflow branches to 008h
// - enabled timer 1 overflow branches to 00ch
// - taken skip discards fetched word, dummy cycle
// - low byte write jumps within current page
// - jumps use instruction field, returns use stack
// - current page lookup uses pointer page, index
// - last page lookup forces upper bits high
// - lookup high part ignores software writes
// - lookup reads take two instruction cycles
// - stack depth parameter, hidden from software
// - calls and interrupts push, returns pop
// - reset leaves the stack empty
// - full stack holds interrupts until a pop
// - call on full stack overwrites oldest entry
// - rom width parameter, addressed by pointer or table
// - interrupt entry clears global interrupt allow
// - only the pointer is saved on entry
`timescale 1ns/10ps
module program_sequencer_with_stack
  import seq_pkg::*;
#(
  parameter int PC_W = 13,
  parameter int ROM_W = 16,
  parameter int DEPTH = 8,
  parameter bit HAS_T1 = 1'b1
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // program rom
  output logic [PC_W-1:0] rom_addr,
  input wire logic [ROM_W-1:0] rom_data,
  // execute side
  output logic [ROM_W-1:0] exec_word,
  output logic exec_valid,
  output logic [3:0] phase_oh,
  input wire seq_cmd_s cmd,
  // data map access
  input wire reg_wr_s reg_wr,
  input wire logic [7:0] reg_rd_addr,
  output logic [7:0] reg_rd_data,
  // lookup result
  output logic [7:0] lookup_low,
  output logic lookup_low_valid,
  // interrupt unit
  input wire logic irq_ext_n,
  input wire logic ext_en,
  input wire logic t0_req,
  input wire logic t1_req,
  input wire logic global_irq_allow,
  output logic [2:0] irq_ack,
  output logic global_irq_clear,
  output logic global_irq_set
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] DEPTH_FULL =
      (PW+1)'(DEPTH); // full once every entry holds an address

  logic [1:0] rst_sync_r;
  logic rst_n;
  logic [1:0] ext_sync_r;
  logic [1:0] phase_r;
  logic [3:0] phase_oh_r;
  seq_state_e state_r, state_nxt;
  logic [PC_W-1:0] pc_r, pc_nxt;
  logic [ROM_W-1:0] ir_r, ir_nxt;
  logic [PC_W-1:0] tab_addr_r, tab_addr_nxt;
  logic [7:0] index_r, high_r, low_r, rd_r;
  logic low_valid_r;
  logic [2:0] ack_r, ack_nxt;
  logic clr_r, clr_nxt, set_r, set_nxt;
  logic [PW-1:0] sp_r, sp_nxt;
  logic [PW:0] depth_r, depth_nxt;
  logic push, pop;
  logic [PC_W-1:0] push_val;
  logic [PC_W-1:0] stack_mem [DEPTH];

  // step a counter by one at its own width
  function automatic logic [PC_W-1:0] inc_pc(input logic [PC_W-1:0] v);
    inc_pc = v + 1'b1;
  endfunction : inc_pc

  // reset release through two flops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // external request pin synchroniser
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_sync_r <= 2'h3;
    end else begin
      ext_sync_r <= {ext_sync_r[0], irq_ext_n};
    end
  end

  // phase counter and non-overlapping phase enables
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_r <= 2'h0;
      phase_oh_r <= PHASE_OH_RESET;
    end else begin
      phase_r <= phase_r + 1'b1;
      phase_oh_r <= {phase_oh_r[2:0], phase_oh_r[3]};
    end
  end

  // decode of the cycle boundary and requests
  wire boundary = (phase_r == PHASE_LAST);
  wire running = (state_r == ST_RUN);
  wire ptr_low_wr = running && reg_wr.we && (reg_wr.addr == OFF_PTR_LOW);
  wire index_wr = running && reg_wr.we &&
      (reg_wr.addr == OFF_LOOKUP_INDEX);
  wire stack_full = (depth_r == DEPTH_FULL);
  wire ext_want = !ext_sync_r[1] && ext_en;
  wire t1_want = HAS_T1 && t1_req;
  wire irq_ok = global_irq_allow && !stack_full;
  wire take_irq = irq_ok && (ext_want || t0_req || t1_want);
  wire op_plain = (cmd.op == OP_NONE) && !ptr_low_wr;
  wire [PC_W-1:0] stack_top = stack_mem[sp_r - 1'b1];
  wire [PC_W-1:0] target = cmd.target[PC_W-1:0];
  wire [PC_W-1:0] page_cur = {pc_r[PC_W-1:8], index_r};
  wire [PC_W-1:0] page_last = {{(PC_W-8){1'b1}}, index_r};

  // highest priority vector and its acknowledge bit
  logic [PC_W-1:0] irq_vec;
  logic [2:0] irq_pick;
  always_comb begin
    irq_vec = VEC_T1[PC_W-1:0];
    irq_pick = 3'h0;
    irq_pick[ACK_T1] = 1'b1;
    if (ext_want) begin
      irq_vec = VEC_EXT[PC_W-1:0];
      irq_pick = 3'h0;
      irq_pick[ACK_EXT] = 1'b1;
    end else if (t0_req) begin
      irq_vec = VEC_T0[PC_W-1:0];
      irq_pick = 3'h0;
      irq_pick[ACK_T0] = 1'b1;
    end
  end

  // next state of the sequencer at each cycle boundary
  always_comb begin
    state_nxt = state_r;
    pc_nxt = pc_r;
    ir_nxt = ir_r;
    tab_addr_nxt = tab_addr_r;
    ack_nxt = 3'h0;
    clr_nxt = 1'b0;
    set_nxt = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    push_val = pc_r;
    if (boundary) begin
      case (state_r)
        ST_RUN: begin
          case (cmd.op)
            OP_JUMP: begin
              pc_nxt = target;
              state_nxt = ST_FLUSH;
            end
            OP_CALL: begin
              push = 1'b1;
              pc_nxt = target;
              state_nxt = ST_FLUSH;
            end
            OP_RET, OP_ISR_RETURN_OP: begin
              pop = 1'b1;
              pc_nxt = stack_top;
              set_nxt = (cmd.op == OP_ISR_RETURN_OP);
              state_nxt = ST_FLUSH;
            end
            OP_SKIP: begin
              pc_nxt = inc_pc(pc_r);
              state_nxt = ST_FLUSH;
            end
            OP_TAB_CUR, OP_TAB_LAST: begin
              tab_addr_nxt = (cmd.op == OP_TAB_CUR) ? page_cur : page_last;
              ir_nxt = rom_data;
              pc_nxt = inc_pc(pc_r);
              state_nxt = ST_TABLE;
            end
            default: begin
              if (ptr_low_wr) begin
                pc_nxt = {pc_r[PC_W-1:8], reg_wr.data};
                state_nxt = ST_FLUSH;
              end else if (op_plain && take_irq) begin
                push = 1'b1;
                pc_nxt = irq_vec;
                ack_nxt = irq_pick;
                clr_nxt = 1'b1;
                state_nxt = ST_FLUSH;
              end else begin
                ir_nxt = rom_data;
                pc_nxt = inc_pc(pc_r);
              end
            end
          endcase
        end
        ST_FLUSH: begin
          ir_nxt = rom_data;
          pc_nxt = inc_pc(pc_r);
          state_nxt = ST_RUN;
        end
        ST_TABLE: begin
          state_nxt = ST_RUN;
        end
        default: begin
          state_nxt = ST_FLUSH;
        end
      endcase
    end
  end

  // stack pointer and depth after a push or pop
  always_comb begin
    sp_nxt = sp_r;
    depth_nxt = depth_r;
    if (push) begin
      sp_nxt = (sp_r == PW'(DEPTH - 1)) ? '0 : sp_r + 1'b1;
      depth_nxt = stack_full ? depth_r : depth_r + 1'b1;
    end else if (pop) begin
      sp_nxt = (sp_r == '0) ? PW'(DEPTH - 1) : sp_r - 1'b1;
      depth_nxt = (depth_r == '0) ? depth_r : depth_r - 1'b1;
    end
  end

  // sequencer registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_FLUSH;
      pc_r <= VEC_RESET[PC_W-1:0];
      ir_r <= '0;
      tab_addr_r <= '0;
      ack_r <= 3'h0;
      clr_r <= 1'b0;
      set_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      pc_r <= pc_nxt;
      ir_r <= ir_nxt;
      tab_addr_r <= tab_addr_nxt;
      ack_r <= ack_nxt;
      clr_r <= clr_nxt;
      set_r <= set_nxt;
    end
  end

  // stack index, empty after reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sp_r <= '0;
      depth_r <= '0;
    end else begin
      sp_r <= sp_nxt;
      depth_r <= depth_nxt;
    end
  end

  // stack storage, circular so the oldest entry is overwritten
  always_ff @(posedge clk) begin
    if (push) begin
      stack_mem[sp_r] <= push_val;
    end
  end

  // lookup index register and lookup result capture
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      index_r <= LOOKUP_INDEX_RESET;
      high_r <= LOOKUP_HIGH_RESET;
      low_r <= 8'h00;
      low_valid_r <= 1'b0;
    end else begin
      low_valid_r <= 1'b0;
      if (boundary && index_wr) begin
        index_r <= reg_wr.data;
      end
      if (boundary && state_r == ST_TABLE) begin
        low_r <= rom_data[7:0];
        high_r <= 8'(rom_data[ROM_W-1:8]);
        low_valid_r <= 1'b1;
      end
    end
  end

  // read port of the mapped registers, stack never visible
  wire [7:0] rd_sel = (reg_rd_addr == OFF_PTR_LOW) ? pc_r[7:0] :
      (reg_rd_addr == OFF_LOOKUP_INDEX) ? index_r :
      (reg_rd_addr == OFF_LOOKUP_HIGH) ? high_r : UNMAPPED_READ;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_r <= UNMAPPED_READ;
    end else begin
      rd_r <= rd_sel;
    end
  end

  // outputs
  assign rom_addr = (state_r == ST_TABLE) ? tab_addr_r : pc_r;
  assign exec_word = ir_r;
  assign exec_valid = running;
  assign phase_oh = phase_oh_r;
  assign reg_rd_data = rd_r;
  assign lookup_low = low_r;
  assign lookup_low_valid = low_valid_r;
  assign irq_ack = ack_r;
  assign global_irq_clear = clr_r;
  assign global_irq_set = set_r;

endmodule : program_sequencer_with_stack

// >>> seq_rom_model.sv
// program rom model: one combinational word per address
`timescale 1ns/10ps
module seq_rom_model #(
  parameter int PC_W = 10,
  parameter int ROM_W = 14
) (
  // rom port
  input wire logic [PC_W-1:0] rom_addr,
  output logic [ROM_W-1:0] rom_data
);
  // page bits folded into the high part so pages differ
  assign rom_data = ROM_W'({6'h2a ^ {rom_addr[9:8], rom_addr[3:0]},
    rom_addr[7:0]});
endmodule : seq_rom_model

// >>> seq_assertions.sv
// port assertions of the program sequencer
`timescale 1ns/10ps
module seq_assertions
  import seq_pkg::*;
#(
  parameter int PC_W = 13
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // watched ports
  input wire logic [PC_W-1:0] rom_addr,
  input wire logic exec_valid,
  input wire logic [3:0] phase_oh,
  input wire seq_cmd_s cmd,
  input wire reg_wr_s reg_wr,
  input wire logic lookup_low_valid,
  input wire logic global_irq_allow,
  input wire logic [2:0] irq_ack,
  input wire logic global_irq_clear
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // edge at which the executing op is taken
  wire taken = exec_valid && phase_oh == 4'h8;
  sequence s_dummy;
    !exec_valid [*4] ##1 exec_valid;
  endsequence
  property p_phase;
    phase_oh == 4'h8 |=> phase_oh == 4'h1;
  endproperty
  a_phase: assert property (p_phase)
    else $error("phase did not wrap");
  property p_stands;
    phase_oh != 4'h8 |=> $stable(exec_valid);
  endproperty
  a_stands: assert property (p_stands)
    else $error("exec valid changed mid cycle");
  property p_jump;
    taken && cmd.op == OP_JUMP |=>
      rom_addr == $past(cmd.target[PC_W-1:0]) ##0 s_dummy;
  endproperty
  a_jump: assert property (p_jump)
    else $error("jump target or dummy cycle wrong");
  property p_tab;
    taken && cmd.op == OP_TAB_LAST |=>
      (&rom_addr[PC_W-1:8]) ##0 s_dummy ##0 lookup_low_valid;
  endproperty
  a_tab: assert property (p_tab)
    else $error("last page lookup wrong");
  property p_step;
    taken && cmd.op == OP_NONE && !reg_wr.we && !global_irq_allow |=>
      exec_valid && rom_addr == PC_W'($past(rom_addr) + 1'b1);
  endproperty
  a_step: assert property (p_step)
    else $error("pointer did not step");
  property p_skip;
    taken && cmd.op == OP_SKIP |=>
      rom_addr == PC_W'($past(rom_addr) + 1'b1) ##0 s_dummy;
  endproperty
  a_skip: assert property (p_skip)
    else $error("skip wrong");
  property p_ext;
    irq_ack[0] |-> rom_addr == VEC_EXT[PC_W-1:0] && global_irq_clear;
  endproperty
  a_ext: assert property (p_ext)
    else $error("external vector wrong");
  property p_t0;
    irq_ack[1] |-> rom_addr == VEC_T0[PC_W-1:0] && global_irq_clear;
  endproperty
  a_t0: assert property (p_t0)
    else $error("timer 0 vector wrong");
endmodule : seq_assertions
bind program_sequencer_with_stack seq_assertions #(.PC_W(PC_W))
  i_seq_assertions (.clk, .reset_n, .rom_addr, .exec_valid, .phase_oh,
  .cmd, .reg_wr, .lookup_low_valid, .global_irq_allow, .irq_ack,
  .global_irq_clear);

// >>> tb_top.sv
// self-checking bench of the program sequencer
`timescale 1ns/10ps
module tb_top;
  import seq_pkg::*;
  localparam int PC_W = 10;
  localparam int ROM_W = 14;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [PC_W-1:0] rom_addr;
  logic [ROM_W-1:0] rom_data, exec_word;
  logic exec_valid, lookup_low_valid, global_irq_clear, global_irq_set;
  logic [3:0] phase_oh;
  seq_cmd_s cmd = '0;
  reg_wr_s reg_wr = '0;
  logic [7:0] reg_rd_addr = 8'h00;
  logic [7:0] reg_rd_data, lookup_low, v;
  logic irq_ext_n = 1'b1, ext_en = 1'b0, t0_req = 1'b0, t1_req = 1'b0;
  logic global_irq_allow = 1'b0;
  logic [2:0] irq_ack, ack_seen = 3'h0;
  int fails = 0, checked = 0, cycles = 0;
  program_sequencer_with_stack #(.PC_W(PC_W), .ROM_W(ROM_W), .DEPTH(2),
    .HAS_T1(1'b1)) i_program_sequencer_with_stack (.clk, .reset_n,
    .rom_addr, .rom_data, .exec_word, .exec_valid, .phase_oh, .cmd, .reg_wr,
    .reg_rd_addr, .reg_rd_data, .lookup_low, .lookup_low_valid, .irq_ext_n,
    .ext_en, .t0_req, .t1_req, .global_irq_allow, .irq_ack,
    .global_irq_clear, .global_irq_set);
  seq_rom_model #(.PC_W(PC_W), .ROM_W(ROM_W)) i_seq_rom_model (.rom_addr,
    .rom_data);
  // clock
  always #12.5 clk = ~clk;
  // interrupt unit stand-in and hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles > 5000) begin
      fails++;
      results();
    end
    #2;
    if (global_irq_clear === 1'b1) global_irq_allow = 1'b0;
    if (global_irq_set === 1'b1) global_irq_allow = 1'b1;
    if (irq_ack !== 3'h0) ack_seen = irq_ack;
  end
  task automatic chk(input string n, input logic [15:0] e,
      input logic [15:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // hands one op to the sequencer at the end of an executing cycle
  task automatic issue(input seq_op_e o, input logic [15:0] t,
      input logic we = 1'b0, input logic [7:0] a = 8'h00);
    int n = 0;
    while (!(exec_valid === 1'b1 && phase_oh === 4'h8) && n < 200) begin
      @(posedge clk);
      #2;
      n++;
    end
    cmd = '{o, t};
    reg_wr = '{we, a, t[7:0]};
    @(posedge clk);
    #2;
    cmd = '0;
    reg_wr = '0;
  endtask : issue
  // waits for the next executed word, checks its address low byte
  task automatic at(input logic [7:0] e);
    int n = 0;
    while (exec_valid !== 1'b1 && n < 200) begin
      @(posedge clk);
      #2;
      n++;
    end
    chk("exec address", 16'(e), 16'(exec_word[7:0]));
  endtask : at
  task automatic rd(input logic [7:0] a);
    reg_rd_addr = a;
    repeat (2) @(posedge clk);
    #2;
    v = reg_rd_data;
  endtask : rd
  function automatic logic [15:0] hi(input logic [9:0] a);
    return 16'(6'h2a ^ {a[9:8], a[3:0]});
  endfunction : hi
  task automatic results();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results
  // main sequence
  initial begin
    repeat (2) @(posedge clk);
    #2;
    reset_n = 1'b1;
    at(8'h00);
    issue(OP_JUMP, 16'h0155);
    chk("dummy", 16'h0, 16'(exec_valid));
    at(8'h55);
    issue(OP_NONE, 16'h0);
    at(8'h56);
    issue(OP_SKIP, 16'h0);
    at(8'h58);
    issue(OP_NONE, 16'h0020, 1'b1, OFF_PTR_LOW);
    at(8'h20);
    rd(OFF_PTR_LOW);
    chk("pointer low", 16'h0021, 16'(v));
    $display("test flow done");
    issue(OP_NONE, 16'h009a, 1'b1, OFF_LOOKUP_INDEX);
    issue(OP_TAB_CUR, 16'h0);
    at(8'h22);
    chk("lookup low", 16'h009a, 16'(lookup_low));
    rd(OFF_LOOKUP_HIGH);
    chk("lookup high", hi(10'h19a), 16'(v));
    issue(OP_NONE, 16'h00ff, 1'b1, OFF_LOOKUP_HIGH);
    rd(OFF_LOOKUP_HIGH);
    chk("high kept", hi(10'h19a), 16'(v));
    issue(OP_TAB_LAST, 16'h0);
    at(8'h24);
    rd(OFF_LOOKUP_HIGH);
    chk("last page high", hi(10'h39a), 16'(v));
    $display("test lookup done");
    issue(OP_JUMP, 16'h0200);
    at(8'h00);
    issue(OP_CALL, 16'h0040);
    at(8'h40);
    issue(OP_CALL, 16'h0080);
    at(8'h80);
    issue(OP_CALL, 16'h00c0);
    at(8'hc0);
    issue(OP_RET, 16'h0);
    at(8'h81);
    issue(OP_RET, 16'h0);
    at(8'h41);
    $display("test stack done");
    issue(OP_CALL, 16'h0100);
    at(8'h00);
    issue(OP_CALL, 16'h0180);
    at(8'h80);
    global_irq_allow = 1'b1;
    t0_req = 1'b1;
    repeat (3) issue(OP_NONE, 16'h0);
    chk("held ack", 16'h0, 16'(ack_seen));
    issue(OP_RET, 16'h0);
    at(8'h01);
    issue(OP_NONE, 16'h0);
    at(8'h08);
    chk("t0 ack", 16'h2, 16'(ack_seen));
    chk("allow cleared", 16'h0, 16'(global_irq_allow));
    $display("test full stack done");
    ack_seen = 3'h0;
    irq_ext_n = 1'b0;
    ext_en = 1'b1;
    t1_req = 1'b1;
    issue(OP_ISR_RETURN_OP, 16'h0);
    at(8'h02);
    issue(OP_NONE, 16'h0);
    at(8'h04);
    chk("ext first", 16'h1, 16'(ack_seen));
    irq_ext_n = 1'b1;
    ext_en = 1'b0;
    t0_req = 1'b0;
    issue(OP_ISR_RETURN_OP, 16'h0);
    at(8'h03);
    issue(OP_NONE, 16'h0);
    at(8'h0c);
    chk("t1 ack", 16'h4, 16'(ack_seen));
    $display("test priority done");
    results();
  end
endmodule : tb_top
